// ---- rtl/gpia_defines.svh ----
// Register offsets, field positions, reset values and layout masks of the event aggregator
`ifndef GPIA_DEFINES_SVH
`define GPIA_DEFINES_SVH

`define GPIA_ADDR_W             20
`define GPIA_GT_STATUS_OFF      20'h44010
`define GPIA_GT_MASK_OFF        20'h44014
`define GPIA_GT_IDENTITY_OFF    20'h44018
`define GPIA_GT_ENABLE_OFF      20'h4401c
`define GPIA_PM_STATUS_OFF      20'h44020
`define GPIA_PM_MASK_OFF        20'h44024
`define GPIA_PM_IDENTITY_OFF    20'h44028
`define GPIA_PM_ENABLE_OFF      20'h4402c

`define GPIA_GT_MASK_RST        32'hffffffff
`define GPIA_PM_MASK_RST        32'h0fffffff
`define GPIA_IDENTITY_RST       32'h00000000
`define GPIA_ENABLE_RST         32'h00000000

// Implemented bits of the graphics-engine and power-management layouts
`define GPIA_GT_VALID           32'h675dd1dd
`define GPIA_PM_MAILBOX_BIT     25
`define GPIA_PM_THERMAL_BIT     24
`define GPIA_PM_IDLE_DOWN_BIT   6
`define GPIA_PM_UP_THR_BIT      5
`define GPIA_PM_DOWN_THR_BIT    4
`define GPIA_PM_UP_EVAL_BIT     2
`define GPIA_PM_DOWN_EVAL_BIT   1
`define GPIA_PM_VALID           32'h03000076

`endif

// ---- rtl/gpia_pkg.sv ----
// Types shared by the event aggregator
package gpia_pkg;
    typedef logic [31:0] gpia_word_t;
    typedef enum logic [1:0] {
        GPIA_ID_IDLE,
        GPIA_ID_SET,
        GPIA_ID_SET_PENDING,
        GPIA_ID_GAP
    } gpia_id_state_t;
endpackage

// ---- rtl/gpia_aggregator.sv ----
// Graphics-engine and power-management interrupt aggregation registers
`timescale 1ns/10ps
`include "gpia_defines.svh"

// What this block does
// [R1] Unmasked status latches into identity until W1C
// [R2] Identity remembers one extra pending occurrence
// [R3] Clear with pending: bit drops, then returns
// [R4] Mask 0 reports, mask 1 blocks
// [R5] Enable per identity bit gates interrupt
// [R6] Disabled identity bits still set, readable
// [R7] Interrupt ORs display, graphics, power groups
// [R8] Display master enable gates all interrupts
// [R9] Status reads live conditions, read only
// [R10] Software must not sample pulsed status
// [R11] Graphics registers share one bit layout
// [R12] Power registers share documented layout
// [R13] Software masks power events in power unit
// [R14] Software reads identity first on interrupt
// [R15] Zero writes, status, reserved enable and identity bits ignored
// [R16] Event beats simultaneous clear
module gpia_aggregator
    import gpia_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic [31:0]             gt_event_in,
    input  wire logic                    power_unit_mailbox_event,
    input  wire logic                    power_unit_thermal_event,
    input  wire logic                    idle_down_timeout_event,
    input  wire logic                    perf_up_threshold,
    input  wire logic                    perf_down_threshold,
    input  wire logic                    perf_up_eval_event,
    input  wire logic                    perf_down_eval_event,
    input  wire logic                    display_event_pending,
    input  wire logic                    display_master_enable,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [`GPIA_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]             reg_wdata,
    output logic      [31:0]             reg_rdata,
    output logic                         reg_rvalid,
    output logic                         cpu_irq
);

    // Event pins come from other clock domains; two stages before use
    gpia_word_t gt_sync1_q, gt_sync2_q;
    gpia_word_t pm_sync1_q, pm_sync2_q;
    logic       de_sync1_q, de_sync2_q, mst_sync1_q, mst_sync2_q;
    gpia_word_t pm_raw;

    assign pm_raw = {6'h00, power_unit_mailbox_event, power_unit_thermal_event, 17'h00000,
                     idle_down_timeout_event, perf_up_threshold, perf_down_threshold, 1'b0,
                     perf_up_eval_event, perf_down_eval_event, 1'b0};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gt_sync1_q  <= '0;
            gt_sync2_q  <= '0;
            pm_sync1_q  <= '0;
            pm_sync2_q  <= '0;
            de_sync1_q  <= 1'b0;
            de_sync2_q  <= 1'b0;
            mst_sync1_q <= 1'b0;
            mst_sync2_q <= 1'b0;
        end else begin
            gt_sync1_q  <= gt_event_in;
            gt_sync2_q  <= gt_sync1_q;
            pm_sync1_q  <= pm_raw;
            pm_sync2_q  <= pm_sync1_q;
            de_sync1_q  <= display_event_pending;
            de_sync2_q  <= de_sync1_q;
            mst_sync1_q <= display_master_enable;
            mst_sync2_q <= mst_sync1_q;
        end
    end

    // Live status view; writes to these offsets fall through the decode
    gpia_word_t gt_status, pm_status;
    // Reserved lanes are dropped only after the second stage
    assign gt_status = gt_sync2_q & `GPIA_GT_VALID;                                // R9 R11
    assign pm_status = pm_sync2_q & `GPIA_PM_VALID;                                // R9 R12

    // Edge detect so a held condition counts once, not every cycle
    gpia_word_t gt_prev_q, pm_prev_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gt_prev_q <= '0;
            pm_prev_q <= '0;
        end else begin
            gt_prev_q <= gt_status;
            pm_prev_q <= pm_status;
        end
    end

    function automatic gpia_word_t rise(input gpia_word_t now, input gpia_word_t prev);
        rise = now & ~prev;
    endfunction

    // Address decode
    wire hit_gt_status = (reg_addr == `GPIA_GT_STATUS_OFF);
    wire hit_gt_mask   = (reg_addr == `GPIA_GT_MASK_OFF);
    wire hit_gt_id     = (reg_addr == `GPIA_GT_IDENTITY_OFF);
    wire hit_gt_en     = (reg_addr == `GPIA_GT_ENABLE_OFF);
    wire hit_pm_status = (reg_addr == `GPIA_PM_STATUS_OFF);
    wire hit_pm_mask   = (reg_addr == `GPIA_PM_MASK_OFF);
    wire hit_pm_id     = (reg_addr == `GPIA_PM_IDENTITY_OFF);
    wire hit_pm_en     = (reg_addr == `GPIA_PM_ENABLE_OFF);

    // Mask and enable storage; reserved bits never store in enable, masks store all 32 bits
    gpia_word_t gt_mask_q, gt_en_q, pm_mask_q, pm_en_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gt_mask_q <= `GPIA_GT_MASK_RST;
            gt_en_q   <= `GPIA_ENABLE_RST;
            pm_mask_q <= `GPIA_PM_MASK_RST;
            pm_en_q   <= `GPIA_ENABLE_RST;
        end else if (reg_wr) begin
            if (hit_gt_mask)
                gt_mask_q <= reg_wdata;                                            // R4
            if (hit_gt_en)
                gt_en_q   <= reg_wdata & `GPIA_GT_VALID;                           // R5 R15
            if (hit_pm_mask)
                pm_mask_q <= reg_wdata;                                            // R4
            if (hit_pm_en)
                pm_en_q   <= reg_wdata & `GPIA_PM_VALID;                           // R5 R15
        end
    end

    // Unmasked rising events and write-one clears
    gpia_word_t gt_evt, pm_evt, gt_clr, pm_clr;
    assign gt_evt = rise(gt_status, gt_prev_q) & ~gt_mask_q;                       // R1 R4
    assign pm_evt = rise(pm_status, pm_prev_q) & ~pm_mask_q;                       // R1 R4
    assign gt_clr = (reg_wr && hit_gt_id) ? (reg_wdata & `GPIA_GT_VALID) : '0;     // R15
    assign pm_clr = (reg_wr && hit_pm_id) ? (reg_wdata & `GPIA_PM_VALID) : '0;     // R15

    // Per-bit identity cell: set, set with one pending, and a one-cycle low gap
    function automatic gpia_id_state_t id_next(input gpia_id_state_t cur,
                                               input logic evt, input logic clr);
        id_next = cur;
        case (cur)
            GPIA_ID_IDLE: begin
                if (evt)
                    id_next = GPIA_ID_SET;                                         // R1
            end
            GPIA_ID_SET: begin
                if (evt)
                    id_next = GPIA_ID_SET_PENDING;                                 // R2 R16
                else if (clr)
                    id_next = GPIA_ID_IDLE;                                        // R1
            end
            GPIA_ID_SET_PENDING: begin
                if (clr && !evt)
                    id_next = GPIA_ID_GAP;                                         // R3
            end
            GPIA_ID_GAP: begin
                id_next = evt ? GPIA_ID_SET_PENDING : GPIA_ID_SET;                 // R3
            end
            default: id_next = GPIA_ID_IDLE;
        endcase
    endfunction

    gpia_id_state_t gt_id_q [32];
    gpia_id_state_t pm_id_q [32];
    gpia_word_t     gt_id, pm_id;

    for (genvar i = 0; i < 32; i++) begin : g_cell
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                gt_id_q[i] <= GPIA_ID_IDLE;
                pm_id_q[i] <= GPIA_ID_IDLE;
            end else begin
                gt_id_q[i] <= id_next(gt_id_q[i], gt_evt[i], gt_clr[i]);
                pm_id_q[i] <= id_next(pm_id_q[i], pm_evt[i], pm_clr[i]);
            end
        end
        // Visible bit is high in both set states, low in the gap
        assign gt_id[i] = (gt_id_q[i] == GPIA_ID_SET) ||
                          (gt_id_q[i] == GPIA_ID_SET_PENDING);                     // R6
        assign pm_id[i] = (pm_id_q[i] == GPIA_ID_SET) ||
                          (pm_id_q[i] == GPIA_ID_SET_PENDING);                     // R6
    end

    // Interrupt combine; registered so the output is a flop
    wire irq_d = mst_sync2_q &&                                                    // R8
                 (de_sync2_q || |(gt_id & gt_en_q) || |(pm_id & pm_en_q));         // R5 R7

    // Read mux; unmapped offsets and reserved bits read zero, except mask registers which read all stored bits
    gpia_word_t rd_d;
    assign rd_d = hit_gt_status ? gt_status :
                  hit_gt_mask   ? gt_mask_q :
                  hit_gt_id     ? gt_id     :
                  hit_gt_en     ? gt_en_q   :
                  hit_pm_status ? pm_status :
                  hit_pm_mask   ? pm_mask_q :
                  hit_pm_id     ? pm_id     :
                  hit_pm_en     ? pm_en_q   : '0;                                  // R15

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cpu_irq    <= 1'b0;
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            cpu_irq    <= irq_d;
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_d;
        end
    end

endmodule

// ---- sim/gpia_aggregator_assertions.sv ----
// Port-level assertions for the event aggregator
`timescale 1ns/10ps
`include "gpia_defines.svh"
module gpia_aggregator_checker
    import gpia_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [31:0] gt_event_in,
    input wire logic        power_unit_mailbox_event,
    input wire logic        power_unit_thermal_event,
    input wire logic        idle_down_timeout_event,
    input wire logic        perf_up_threshold,
    input wire logic        perf_down_threshold,
    input wire logic        perf_up_eval_event,
    input wire logic        perf_down_eval_event,
    input wire logic        display_event_pending,
    input wire logic        display_master_enable,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [19:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        cpu_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic th = power_unit_thermal_event;
    chk_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_rdata_held: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (reg_rd && reg_addr == 20'h44030 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_pm_reserved_zero: assert property (reg_rd && reg_addr == `GPIA_PM_IDENTITY_OFF
        |=> (reg_rdata & ~`GPIA_PM_VALID) == 32'h0) else $error("power reserved bits set");
    chk_gt_reserved_zero: assert property (reg_rd && reg_addr == `GPIA_GT_IDENTITY_OFF
        |=> (reg_rdata & ~`GPIA_GT_VALID) == 32'h0) else $error("graphics reserved bits set");
    chk_status_live_view: assert property (reg_rd && reg_addr == `GPIA_PM_STATUS_OFF && !$past(rst, 4)
        && $stable(th) && th == $past(th, 2) && th == $past(th, 3) |=> reg_rdata[24] == $past(th))
        else $error("status does not follow condition");
    chk_master_blocks_irq: assert property (!display_master_enable [*4] |=> !cpu_irq)
        else $error("interrupt without master enable");
    chk_display_raises_irq: assert property
        ((display_event_pending && display_master_enable) [*4] |=> cpu_irq)
        else $error("display group did not raise interrupt");
    cover property ($rose(cpu_irq));
    cover property (reg_rd && reg_addr == `GPIA_PM_IDENTITY_OFF ##1 reg_rdata[25]);
    cover property (reg_wr && reg_addr == `GPIA_GT_IDENTITY_OFF);
endmodule

// ---- sim/gpia_aggregator_tb_top.sv ----
// Self-checking bench for the event aggregator
`timescale 1ns/10ps
`include "gpia_defines.svh"
module gpia_aggregator_tb_top import gpia_pkg::*;;
    logic       clk_sys, rst, reg_wr, reg_rd, disp, mst, reg_rvalid, cpu_irq;
    logic [6:0] pm;
    logic [19:0] reg_addr;
    gpia_word_t gt, reg_wdata, reg_rdata, q[$];
    int         mismatches, num_checks, i;
    gpia_word_t tab[9] = '{32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h0fffffff, 32'h0, 32'h0, 32'h0};
    int         pos[7] = '{25, 24, 6, 5, 4, 2, 1};
    gpia_aggregator gpia_aggregator_inst (.clk_sys(clk_sys), .rst(rst), .gt_event_in(gt),
        .power_unit_mailbox_event(pm[6]), .power_unit_thermal_event(pm[5]),
        .idle_down_timeout_event(pm[4]), .perf_up_threshold(pm[3]), .perf_down_threshold(pm[2]),
        .perf_up_eval_event(pm[1]), .perf_down_eval_event(pm[0]), .display_event_pending(disp),
        .display_master_enable(mst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cpu_irq(cpu_irq));
    // Read data is collected here so back-to-back reads need no per-read handshake
    always @(posedge clk_sys) if (reg_rvalid === 1'b1) q.push_back(reg_rdata);
    task automatic ck(input gpia_word_t s, input gpia_word_t e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic op(input logic w, input logic r, input logic [19:0] a, input gpia_word_t d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic get(input gpia_word_t e);
        for (int n = 0; n < 8 && q.size() == 0; n++) @(posedge clk_sys);
        if (q.size() == 0) begin
            mismatches++;
            test_done;
        end
        ck(q.pop_front(), e);
    endtask
    task automatic rd(input logic [19:0] a, input gpia_word_t e);
        op(1'b0, 1'b1, a, 32'h0);
        op(1'b0, 1'b0, a, 32'h0);
        get(e);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        pm[k] <= 1'b1;
        @(posedge clk_sys);
        pm[k] <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        {reg_wr, reg_rd, disp, mst, pm, gt, reg_addr, reg_wdata} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 9; i++) rd(20'h44010 + 20'(4 * i), tab[i]);
        op(1'b1, 1'b0, `GPIA_PM_STATUS_OFF, 32'hffffffff);
        rd(`GPIA_PM_STATUS_OFF, 32'h0);
        op(1'b1, 1'b0, `GPIA_PM_MASK_OFF, 32'h0);
        for (i = 0; i < 7; i++) begin
            pulse(6 - i);
            rd(`GPIA_PM_IDENTITY_OFF, 32'h1 << pos[i]);
            ck({31'h0, cpu_irq}, 32'h0);
            op(1'b1, 1'b0, `GPIA_PM_IDENTITY_OFF, 32'h0);
            rd(`GPIA_PM_IDENTITY_OFF, 32'h1 << pos[i]);
            op(1'b1, 1'b0, `GPIA_PM_IDENTITY_OFF, 32'hffffffff);
            rd(`GPIA_PM_IDENTITY_OFF, 32'h0);
        end
        op(1'b1, 1'b0, `GPIA_PM_ENABLE_OFF, 32'h02000000);
        pulse(6);
        pulse(6);
        ck({31'h0, cpu_irq}, 32'h0);
        mst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ck({31'h0, cpu_irq}, 32'h1);
        op(1'b1, 1'b0, `GPIA_PM_IDENTITY_OFF, 32'h02000000);
        op(1'b0, 1'b1, `GPIA_PM_IDENTITY_OFF, 32'h0);
        op(1'b0, 1'b1, `GPIA_PM_IDENTITY_OFF, 32'h0);
        op(1'b0, 1'b0, 20'h0, 32'h0);
        get(32'h0);
        get(32'h02000000);
        op(1'b1, 1'b0, `GPIA_PM_IDENTITY_OFF, 32'h02000000);
        repeat (6) @(posedge clk_sys);
        ck({31'h0, cpu_irq}, 32'h0);
        op(1'b1, 1'b0, `GPIA_GT_MASK_OFF, 32'hfffffffe);
        op(1'b1, 1'b0, `GPIA_GT_ENABLE_OFF, 32'h00000011);
        op(1'b0, 1'b0, 20'h0, 32'h0);
        gt <= 32'h00000011;
        op(1'b0, 1'b0, 20'h0, 32'h0);
        gt <= 32'h0;
        repeat (6) @(posedge clk_sys);
        rd(`GPIA_GT_IDENTITY_OFF, 32'h1);
        ck({31'h0, cpu_irq}, 32'h1);
        op(1'b1, 1'b0, `GPIA_GT_IDENTITY_OFF, 32'h1);
        op(1'b0, 1'b0, 20'h0, 32'h0);
        disp <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ck({31'h0, cpu_irq}, 32'h1);
        mst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        ck({31'h0, cpu_irq}, 32'h0);
        // Mid-run reset must drop a live identity bit and restore the mask
        pulse(5);
        rd(`GPIA_PM_IDENTITY_OFF, 32'h01000000);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`GPIA_PM_IDENTITY_OFF, 32'h0);
        rd(`GPIA_PM_MASK_OFF, `GPIA_PM_MASK_RST);
        ck({31'h0, cpu_irq}, 32'h0);
        test_done;
    end
endmodule
bind gpia_aggregator gpia_aggregator_checker gpia_aggregator_checker_inst (.clk_sys(clk_sys),
    .rst(rst), .gt_event_in(gt_event_in), .power_unit_mailbox_event(power_unit_mailbox_event),
    .power_unit_thermal_event(power_unit_thermal_event), .perf_up_threshold(perf_up_threshold),
    .idle_down_timeout_event(idle_down_timeout_event), .perf_up_eval_event(perf_up_eval_event),
    .perf_down_threshold(perf_down_threshold), .perf_down_eval_event(perf_down_eval_event),
    .display_event_pending(display_event_pending), .display_master_enable(display_master_enable),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cpu_irq(cpu_irq));
